// ===== ppmc_port_ctrl.sv
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "ppmc_params.svh"

// What this block does
// - Mode bits 00 quasi, 01 push-pull, 10 input-only, 11 open-drain.
// - Every pin has its own pair of mode bits set by software.
// - Fuse enabled: all pins input-only after reset, port 1 bit 4 quasi.
// - Fuse disabled: pins quasi and weakly high after reset, except port 1 bits 0,1.
// - Port 1 bits 0 and 1 always reset to input-only.
// - Power-down disables inputs except port 1 bit 3, port 3 bits 2 and 3.
// - Quasi mode: very weak pull-up on whenever the latch holds one.
// - Quasi mode: weak pull-up on only while latch and sensed pin are one.
// - Quasi mode: latch rising from zero to one gives two cycles of strong pull-up.
// - Quasi mode: latch zero drives the pin low through the pull-down.
// - Input-only mode: all drivers, pull-ups and pull-down off.
// - Open-drain: pull-ups off, pull-down on only while latch is zero.
// - Push-pull: strong pull-up while latch one, pull-down while zero.
// - Comparator enable forces port 1 bits 0 and 1 input buffers off.
// - Plain reads return the sampled pin levels, zero for pins whose input buffer is off.
// - Read-modify-write reads return the whole port latch.
module ppmc_port_ctrl
(
  // Clock and reset
  input  wire logic                         core_clk_in,
  input  wire logic                         rstn_in,
  // Register port
  input  wire logic [2:0]                   reg_addr_in,
  input  wire logic [7:0]                   reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  input  wire logic                         reg_rmw_in,
  output logic      [7:0]                   reg_rdata_out,
  // System controls
  input  wire logic                         tristate_fuse_in,
  input  wire logic                         power_down_in,
  output logic                              comparator_enable_bit_out,
  // Pins: index 0 is port 1, index 1 is port 3
  input  wire logic [1:0][7:0]              pin_in,
  output ppmc_pkg::ppmc_pin_ctrl_t [1:0]    pin_ctrl_out
);

  localparam logic [2:0] PORT_BASE [2] = '{`PPMC_REG_P1_BASE, `PPMC_REG_P3_BASE};
  localparam logic [7:0] WAKE_MASK [2] = '{`PPMC_P1_WAKE, `PPMC_P3_WAKE};

  function automatic logic reg_hit(input logic [2:0] addr, input int p, input logic [2:0] ofs);
    reg_hit = (addr == 3'(PORT_BASE[p] + ofs));
  endfunction

  function automatic ppmc_pkg::ppmc_mode_t pin_mode(input logic hi, input logic lo);
    pin_mode = ppmc_pkg::ppmc_mode_t'({hi, lo});
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////

  logic [1:0][7:0] pin_s1_q;
  logic [1:0][7:0] pin_s2_q;
  logic            fuse_s1_q;
  logic            fuse_s2_q;

  // Pads are asynchronous, so every port passes its own two-stage synchroniser and only
  // the second stage is ever read by the control and read-back logic.
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++)
    begin : g_sync
      always_ff @(posedge core_clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          pin_s1_q[gs] <= 8'h00;
          pin_s2_q[gs] <= 8'h00;
        end
        else
        begin
          pin_s1_q[gs] <= pin_in[gs];
          pin_s2_q[gs] <= pin_s1_q[gs];
        end
      end
    end
  endgenerate

  // The fuse is a strap from outside the clock domain, so it is synchronised and only
  // read once the pair has settled after the reset release.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
    end
    else
    begin
      fuse_s1_q <= tristate_fuse_in;
      fuse_s2_q <= fuse_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////

  logic [1:0]      boot_q;
  logic [1:0]      boot_d;
  logic            fuse_q;
  logic            fuse_d;
  logic [1:0][7:0] latch_q;
  logic [1:0][7:0] latch_d;
  logic [1:0][7:0] msh_q;
  logic [1:0][7:0] msh_d;
  logic [1:0][7:0] msl_q;
  logic [1:0][7:0] msl_d;
  logic            cmp_q;
  logic            cmp_d;

  always_comb
  begin
    boot_d  = (boot_q == `PPMC_BOOT_DONE) ? boot_q : 2'(boot_q + 2'h1);
    fuse_d  = fuse_q;
    latch_d = latch_q;
    msh_d   = msh_q;
    msl_d   = msl_q;
    cmp_d   = cmp_q;
    if (boot_q == `PPMC_BOOT_LOAD)
    begin
      fuse_d = fuse_s2_q;
      msl_d  = '0;
      if (fuse_s2_q)
      begin
        msh_d[0] = ~`PPMC_P1_FUSE_QUASI;
        msh_d[1] = `PPMC_ALL_ONES;
      end
      else
      begin
        msh_d[0] = `PPMC_P1_ANALOG;
        msh_d[1] = `PPMC_ALL_ZEROS;
      end
    end
    else if (reg_wr_in)
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (reg_hit(reg_addr_in, p, `PPMC_OFS_LATCH))
          latch_d[p] = reg_wdata_in;
        if (reg_hit(reg_addr_in, p, `PPMC_OFS_MSH))
          msh_d[p] = reg_wdata_in;
        if (reg_hit(reg_addr_in, p, `PPMC_OFS_MSL))
          msl_d[p] = reg_wdata_in;
      end
      if (reg_addr_in == `PPMC_REG_CMP)
        cmp_d = reg_wdata_in[`PPMC_CMP_EN_BIT];
    end
  end

  // Until the fuse is loaded every pin sits in input-only mode, the safe choice.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      boot_q  <= 2'h0;
      fuse_q  <= 1'b0;
      latch_q <= {2{`PPMC_LATCH_RST}};
      msh_q   <= {2{`PPMC_MSH_RST}};
      msl_q   <= {2{`PPMC_MSL_RST}};
      cmp_q   <= `PPMC_CMP_RST;
    end
    else
    begin
      boot_q  <= boot_d;
      fuse_q  <= fuse_d;
      latch_q <= latch_d;
      msh_q   <= msh_d;
      msl_q   <= msl_d;
      cmp_q   <= cmp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////

  logic [1:0][7:0][1:0]             strong_cnt_q;
  logic [1:0][7:0][1:0]             strong_cnt_d;
  ppmc_pkg::ppmc_pin_ctrl_t [1:0]   ctrl_q;
  ppmc_pkg::ppmc_pin_ctrl_t [1:0]   ctrl_d;

  // Controls are computed from the next latch and mode values so the pins follow a
  // register write at the same edge that stores it.
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++)
    begin : g_port
      ppmc_pkg::ppmc_pin_ctrl_t ctrl_p;
      logic [7:0][1:0]          cnt_p;

      always_comb
      begin
        ppmc_pkg::ppmc_mode_t mode;
        logic                 quasi;
        mode   = ppmc_pkg::PPMC_INPUT;
        quasi  = 1'b0;
        cnt_p  = '0;
        ctrl_p = '0;
        for (int b = 0; b < 8; b++)
        begin
          mode  = pin_mode(msh_d[gp][b], msl_d[gp][b]);
          quasi = (mode == ppmc_pkg::PPMC_QUASI);
          if (quasi && latch_d[gp][b] && !latch_q[gp][b])
            cnt_p[b] = `PPMC_STRONG_CYCLES;
          else if (quasi && latch_d[gp][b] && strong_cnt_q[gp][b] != 2'h0)
            cnt_p[b] = 2'(strong_cnt_q[gp][b] - 2'h1);
          ctrl_p.vweak_pu[b]  = quasi && latch_d[gp][b];
          ctrl_p.weak_pu[b]   = quasi && latch_d[gp][b] && pin_s2_q[gp][b];
          ctrl_p.strong_pu[b] = (cnt_p[b] != 2'h0)
                              || (mode == ppmc_pkg::PPMC_PUSH_PULL && latch_d[gp][b]);
          // Input-only leaves everything off; open-drain never raises a pull-up.
          ctrl_p.pull_dn[b]   = (mode != ppmc_pkg::PPMC_INPUT) && !latch_d[gp][b];
          ctrl_p.in_en[b]     = !(power_down_in && !WAKE_MASK[gp][b]);
          ctrl_p.pin_oe[b]    = ctrl_p.strong_pu[b] || ctrl_p.pull_dn[b];
          ctrl_p.pin_out[b]   = ctrl_p.strong_pu[b];
        end
        // Only port 1 carries the comparator inputs, so the mask applies there alone.
        if (gp == 0 && cmp_d)
          ctrl_p.in_en = ctrl_p.in_en & ~`PPMC_P1_ANALOG;
      end

      assign strong_cnt_d[gp] = cnt_p;
      assign ctrl_d[gp]       = ctrl_p;
    end
  endgenerate

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      strong_cnt_q <= '0;
      ctrl_q       <= '0;
    end
    else
    begin
      strong_cnt_q <= strong_cnt_d;
      ctrl_q       <= ctrl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // A disabled input buffer reads as zero, as the real gate would.
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd_in)
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (reg_hit(reg_addr_in, p, `PPMC_OFS_LATCH))
          rdata_d = reg_rmw_in ? latch_q[p]
                               : (pin_s2_q[p] & ctrl_q[p].in_en);
        if (reg_hit(reg_addr_in, p, `PPMC_OFS_MSH))
          rdata_d = msh_q[p];
        if (reg_hit(reg_addr_in, p, `PPMC_OFS_MSL))
          rdata_d = msl_q[p];
      end
      if (reg_addr_in == `PPMC_REG_CMP)
        rdata_d[`PPMC_CMP_EN_BIT] = cmp_q;
      if (reg_addr_in == `PPMC_REG_STATUS)
      begin
        rdata_d[`PPMC_STAT_FUSE_BIT] = fuse_q;
        rdata_d[`PPMC_STAT_PD_BIT]   = power_down_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata_out             = rdata_q;
  assign comparator_enable_bit_out = cmp_q;
  assign pin_ctrl_out              = ctrl_q;

endmodule

// ===== ppmc_params.svh
`ifndef PPMC_PARAMS_SVH
`define PPMC_PARAMS_SVH

// Register offsets on the plain register port.
`define PPMC_REG_P1_BASE   3'h0
`define PPMC_REG_P3_BASE   3'h3
`define PPMC_OFS_LATCH     3'h0
`define PPMC_OFS_MSH       3'h1
`define PPMC_OFS_MSL       3'h2
`define PPMC_REG_CMP       3'h6
`define PPMC_REG_STATUS    3'h7

// Field positions.
`define PPMC_CMP_EN_BIT    0
`define PPMC_STAT_FUSE_BIT 0
`define PPMC_STAT_PD_BIT   1

// Reset values.
`define PPMC_LATCH_RST     8'hFF
`define PPMC_MSH_RST       8'hFF
`define PPMC_MSL_RST       8'h00
`define PPMC_CMP_RST       1'h0

// Per-pin masks.
`define PPMC_P1_FUSE_QUASI 8'h10
`define PPMC_P1_ANALOG     8'h03
`define PPMC_P1_WAKE       8'h08
`define PPMC_P3_WAKE       8'h0C
`define PPMC_ALL_ONES      8'hFF
`define PPMC_ALL_ZEROS     8'h00

// Timing counts in CPU clock cycles.
`define PPMC_STRONG_CYCLES 2'h2
`define PPMC_BOOT_LOAD     2'h2
`define PPMC_BOOT_DONE     2'h3

`endif

// ===== ppmc_pkg.sv
package ppmc_pkg;

  // Mode code is {pin_mode_select_high, pin_mode_select_low}.
  typedef enum logic [1:0] {
    PPMC_QUASI     = 2'b00,
    PPMC_PUSH_PULL = 2'b01,
    PPMC_INPUT     = 2'b10,
    PPMC_OPEN      = 2'b11
  } ppmc_mode_t;

  typedef struct packed {
    logic [7:0] vweak_pu;
    logic [7:0] weak_pu;
    logic [7:0] strong_pu;
    logic [7:0] pull_dn;
    logic [7:0] in_en;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
  } ppmc_pin_ctrl_t;

endpackage

// ===== ppmc_port_ctrl_assertions.sv
`timescale 1ns/1ps
module ppmc_port_ctrl_assertions
(
  // Clock and reset
  input wire logic                 core_clk_in,
  input wire logic                 rstn_in,
  // Register port
  input wire logic [2:0]           reg_addr_in,
  input wire logic                 reg_rd_in,
  input wire logic                 reg_rmw_in,
  input wire logic [7:0]           reg_rdata_out,
  // Controls and pins
  input wire logic                 tristate_fuse_in,
  input wire logic                 power_down_in,
  input wire logic                 comparator_enable_bit_out,
  input wire logic [1:0][7:0]      pin_in,
  input ppmc_pkg::ppmc_pin_ctrl_t [1:0] pin_ctrl_out
);
  // Both ports side by side, port 3 in the upper byte.
  logic [15:0] vw, wk, st, pd, oe, ie;
  logic [7:0]  rdv;
  assign vw = {pin_ctrl_out[1].vweak_pu, pin_ctrl_out[0].vweak_pu};
  assign wk = {pin_ctrl_out[1].weak_pu, pin_ctrl_out[0].weak_pu};
  assign st = {pin_ctrl_out[1].strong_pu, pin_ctrl_out[0].strong_pu};
  assign pd = {pin_ctrl_out[1].pull_dn, pin_ctrl_out[0].pull_dn};
  assign oe = {pin_ctrl_out[1].pin_oe, pin_ctrl_out[0].pin_oe};
  assign ie = {pin_ctrl_out[1].in_en, pin_ctrl_out[0].in_en};
  assign rdv = pin_in[0] & pin_ctrl_out[0].in_en;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  AST_VW_PD: assert property ((vw & pd) == 16'h0000)
    else $error("very weak pull-up beside pull-down");
  AST_ST_PD: assert property ((st & pd) == 16'h0000 && oe == (st | pd))
    else $error("strong pull-up beside pull-down");
  AST_WK_PIN: assert property (
    (wk & ~($past(pin_in, 2) | $past(pin_in, 3) | $past(pin_in, 4))) == 16'h0000)
    else $error("weak pull-up on a low pin");
  AST_WAKE: assert property (power_down_in |=> (ie & ~16'h0C08) == 16'h0000)
    else $error("input enabled in power-down");
  AST_CMP: assert property (comparator_enable_bit_out |=> ie[1:0] == 2'b00)
    else $error("analog pin input enabled");
  AST_RD_PIN: assert property (
    reg_rd_in && !reg_rmw_in && reg_addr_in == 3'h0 && $stable(pin_in)
    && pin_in == $past(pin_in, 2) && $stable(ie) |=> reg_rdata_out == $past(rdv))
    else $error("plain read not pins");
  AST_BOOT: assert property (
    $rose(rstn_in) |-> ##3 vw == (tristate_fuse_in ? 16'h0010 : 16'hFFFC))
    else $error("wrong default modes");
  AST_BOOT_OE: assert property ($rose(rstn_in) |=> oe == 16'h0000 ##1 oe == 16'h0000)
    else $error("driver on before modes load");
endmodule

bind ppmc_port_ctrl ppmc_port_ctrl_assertions u_chk (.core_clk_in, .rstn_in, .reg_addr_in,
  .reg_rd_in, .reg_rmw_in, .reg_rdata_out, .tristate_fuse_in, .power_down_in,
  .comparator_enable_bit_out, .pin_in, .pin_ctrl_out);

// ===== ppmc_pin_model.sv
`timescale 1ns/1ps
module ppmc_pin_model
(
  // Clock
  input  wire logic                      clk_in,
  // Pad controls and external pull-downs
  input  ppmc_pkg::ppmc_pin_ctrl_t [1:0] ctrl_in,
  input  wire logic [1:0][7:0]           ext_low_in,
  // Pad levels
  output logic      [1:0][7:0]           pin_out
);
  // An undriven pad has no level of its own, so it flips every cycle.
  logic [1:0][7:0] float_q = 16'h00FF;
  always_ff @(posedge clk_in)
    float_q <= ~float_q;
  always_comb
    for (int p = 0; p < 2; p++)
      pin_out[p] = ~ext_low_in[p] & ((ctrl_in[p].pin_oe & ctrl_in[p].pin_out)
        | (~ctrl_in[p].pin_oe & (ctrl_in[p].vweak_pu | ctrl_in[p].weak_pu | float_q[p])));
endmodule

// ===== ppmc_port_ctrl_tb.sv
`timescale 1ns/1ps
module ppmc_port_ctrl_tb;
  logic                           core_clk_in = 1'b0;
  logic                           rstn_in = 1'b0;
  logic [2:0]                     reg_addr_in = 3'h0;
  logic [7:0]                     reg_wdata_in = 8'h00;
  logic                           reg_wr_in = 1'b0;
  logic                           reg_rd_in = 1'b0;
  logic                           reg_rmw_in = 1'b0;
  logic [7:0]                     reg_rdata_out;
  logic                           tristate_fuse_in = 1'b0;
  logic                           power_down_in = 1'b0;
  logic                           comparator_enable_bit_out;
  logic [1:0][7:0]                pin_in;
  logic [1:0][7:0]                ext_low = 16'h0000;
  ppmc_pkg::ppmc_pin_ctrl_t [1:0] pin_ctrl_out;
  int                             n_errors = 0;
  int                             cmp_count = 0;
  int                             cyc = 0;

  initial
    forever #2 core_clk_in = ~core_clk_in;

  ppmc_port_ctrl dut (.core_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rmw_in, .reg_rdata_out, .tristate_fuse_in, .power_down_in,
    .comparator_enable_bit_out, .pin_in, .pin_ctrl_out);
  ppmc_pin_model u_pins (.clk_in(core_clk_in), .ctrl_in(pin_ctrl_out), .ext_low_in(ext_low),
    .pin_out(pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Waits land one step past the edge so all registered outputs have settled.
  task automatic idle(int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    idle(1);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(logic [2:0] a, logic m, string nm, logic [7:0] exp);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rmw_in <= m;
    reg_rd_in <= 1'b1;
    idle(1);
    reg_rd_in <= 1'b0;
    reg_rmw_in <= 1'b0;
    chk(nm, exp, reg_rdata_out);
  endtask

  // The fuse is a strap, so it is set while reset is still held.
  task automatic do_reset(logic f);
    @(posedge core_clk_in);
    rstn_in <= 1'b0;
    tristate_fuse_in <= f;
    repeat (8) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    idle(6);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset(1'b0);
    chk("p1 vweak", 8'hFC, pin_ctrl_out[0].vweak_pu);
    chk("p3 vweak", 8'hFF, pin_ctrl_out[1].vweak_pu);
    $display("reset defaults done");
    wr(3'h3, 8'h0F);
    wr(3'h4, 8'hCC);
    wr(3'h5, 8'hAA);
    idle(6);
    chk("vweak", 8'h01, pin_ctrl_out[1].vweak_pu);
    chk("strong", 8'h02, pin_ctrl_out[1].strong_pu);
    chk("pull_dn", 8'hB0, pin_ctrl_out[1].pull_dn);
    chk("weak", 8'h01, pin_ctrl_out[1].weak_pu);
    chk("oe", 8'hB2, pin_ctrl_out[1].pin_oe);
    chk("pin_out", 8'h02, pin_ctrl_out[1].pin_out);
    rd(3'h4, 1'b0, "p3 msh", 8'hCC);
    rd(3'h3, 1'b1, "p3 latch", 8'h0F);
    wr(3'h3, 8'h1F);
    for (int i = 0; i < 3; i++)
    begin
      chk("pulse", (i < 2) ? 8'h12 : 8'h02, pin_ctrl_out[1].strong_pu);
      idle(1);
    end
    idle(4);
    chk("weak hi", 8'h11, pin_ctrl_out[1].weak_pu);
    ext_low <= 16'h0100;
    idle(6);
    chk("weak lo", 8'h10, pin_ctrl_out[1].weak_pu);
    $display("modes done");
    ext_low <= 16'h0123;
    idle(4);
    rd(3'h0, 1'b0, "p1 pins", 8'hDC);
    rd(3'h0, 1'b1, "p1 latch", 8'hFF);
    wr(3'h6, 8'h01);
    idle(2);
    chk("p1 in_en", 8'hFC, pin_ctrl_out[0].in_en);
    rd(3'h6, 1'b0, "cmp", 8'h01);
    chk("cmp out", 8'h01, {7'h00, comparator_enable_bit_out});
    wr(3'h7, 8'hFF);
    power_down_in <= 1'b1;
    idle(2);
    chk("p1 pd", 8'h08, pin_ctrl_out[0].in_en);
    chk("p3 pd", 8'h0C, pin_ctrl_out[1].in_en);
    rd(3'h7, 1'b0, "status", 8'h02);
    power_down_in <= 1'b0;
    $display("reads done");
    do_reset(1'b1);
    chk("p1 fuse", 8'h10, pin_ctrl_out[0].vweak_pu);
    chk("p3 fuse", 8'h00, pin_ctrl_out[1].vweak_pu);
    chk("cmp rst", 8'h00, {7'h00, comparator_enable_bit_out});
    rd(3'h7, 1'b0, "fuse", 8'h01);
    $display("fuse done");
    close_out();
  end
endmodule
